// ==== common/bcm_consts.svh ====
// constants of the channel b break matcher: offsets, fields, reset values
// Functional notes
// - bus-source bit 0: full 32-bit break address compared with logic/internal address
// - bus-source bit 1: address upper half to X bits 15-1, lower to Y bits 15-1
// - bus-source enable at bit 9 picks logic/internal bus or X/Y pair
// - in X/Y mode, bus-pick bit 8 selects X bus (0) or Y bus (1)
// - address mask bit 1 drops that address bit from comparison
// - in X/Y mode mask halves apply to X or Y address bits 15-1
// - data compared with cpu/cache data, or halves with X/Y data 15-0
// - data mask bit 1 drops that data bit from comparison
// - byte breaks use data bits 15-8 for even, 7-0 for odd address
// - owner field: 00 ignore, x1 core cycles, 10 dma cycles
// - access-type field: 00 ignore, 01 fetch, 10 data, 11 either
// - direction field: 00 ignore, 01 read, 10 write, 11 either
// - size field: 00 ignore, 01 byte, 10 word, 11 longword
// - reset clears address, masks, data and bus-cycle registers to zero
// - bus-cycle bits 15-10 read as zero; software writes zero there
// - data comparison counts only while data-break enable (bit 7) is set
// - a match sets core flag (bit 14) or dma flag (bit 12); write 0 clears
`ifndef BCM_CONSTS_SVH
`define BCM_CONSTS_SVH
`define BCM_OFF_ADDR 8'h00
`define BCM_OFF_AMASK 8'h04
`define BCM_OFF_DATA 8'h08
`define BCM_OFF_DMASK 8'h0C
`define BCM_OFF_CYCLE 8'h10
`define BCM_OFF_CTRL 8'h14
`define BCM_RST32 32'h0000_0000
`define BCM_RST10 10'h000
`define BCM_XYE_BIT 9
`define BCM_XYS_BIT 8
`define BCM_OWNER_RNG 7:6
`define BCM_OWNER_CORE_BIT 6
`define BCM_TYPE_RNG 5:4
`define BCM_DIR_RNG 3:2
`define BCM_SIZE_RNG 1:0
`define BCM_CYCLE_RNG 9:0
`define BCM_DBE_BIT 7
`define BCM_CORE_FLAG_BIT 14
`define BCM_DMA_FLAG_BIT 12
`define BCM_SEL_NONE 2'h0
`define BCM_SZ_BYTE 2'h1
`define BCM_SZ_LONG 2'h3
`define BCM_HI_ALL 16'hFFFF
`define BCM_HI_NONE 16'h0000
`define BCM_LANE_EVEN 32'h0000_00FF
`define BCM_LANE_ODD 32'h0000_FF00
`endif

// ==== common/bcm_pkg.sv ====
// types of the channel b break matcher
package bcm_pkg;
  // one monitored bus cycle, driven by the core/dma bus logic on sys_clk
  typedef struct packed {
    logic valid;
    logic dma;
    logic fetch;
    logic write;
    logic [1:0] size;
    logic [31:0] laddr;
    logic [31:0] ldata;
    logic [15:0] xaddr;
    logic [15:0] yaddr;
    logic [15:0] xdata;
    logic [15:0] ydata;
  } bcm_cycle_t;

  // register port as seen by software
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bcm_reg_req_t;
endpackage

// ==== rtl/bcm_attr_match.sv ====
// owner, access type, direction and size checks of one bus cycle
`timescale 1ns/1ps
`include "bcm_consts.svh"
module bcm_attr_match
  import bcm_pkg::*;
(
  input wire logic [7:0] sel,
  input wire bcm_cycle_t cyc,
  output logic ok
);
  logic own_ok;
  logic typ_ok;
  logic dir_ok;
  logic siz_ok;

  // two-bit either/or select: bit 0 takes the first case, bit 1 the second
  function automatic logic pick2(input logic [1:0] f, input logic first);
    pick2 = (f == `BCM_SEL_NONE) || (f[0] && first) || (f[1] && !first);
  endfunction

  // owner 11 means core as well, so bit 0 wins over bit 1
  assign own_ok = (sel[`BCM_OWNER_RNG] == `BCM_SEL_NONE) ||
                  (sel[`BCM_OWNER_CORE_BIT] ? !cyc.dma : cyc.dma);
  assign typ_ok = pick2(sel[`BCM_TYPE_RNG], cyc.fetch);
  assign dir_ok = pick2(sel[`BCM_DIR_RNG], !cyc.write);
  assign siz_ok = (sel[`BCM_SIZE_RNG] == `BCM_SEL_NONE) ||
                  (sel[`BCM_SIZE_RNG] == cyc.size);
  assign ok = own_ok && typ_ok && dir_ok && siz_ok;
endmodule // bcm_attr_match

// ==== rtl/bcm_masked_cmp.sv ====
// masked equality of a reference word against a bus word
`timescale 1ns/1ps
module bcm_masked_cmp (
  input wire logic [31:0] ref_val,
  input wire logic [31:0] bus_val,
  input wire logic [31:0] mask,
  output logic eq
);
  // a set mask bit lets that bit position differ without breaking equality
  assign eq = &((ref_val ~^ bus_val) | mask);
endmodule // bcm_masked_cmp

// ==== rtl/bcm_matcher_top.sv ====
// channel b break comparator with its register file
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "bcm_consts.svh"
module bcm_matcher_top
  import bcm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire bcm_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  input wire bcm_cycle_t bus_cycle,
  output logic chb_match,
  output logic core_match_flag,
  output logic dma_match_flag,
  output logic data_break_enable
);
  logic [31:0] brk_addr_reg;
  logic [31:0] amask_reg;
  logic [31:0] brk_data_reg;
  logic [31:0] dmask_reg;
  logic [9:0] cycle_sel_reg;
  logic dbe_reg;
  logic core_flag_reg;
  logic dma_flag_reg;
  logic match_reg;
  logic [31:0] rdata_reg;
  logic [31:0] a_ref;
  logic [31:0] a_bus;
  logic [31:0] a_msk;
  logic [31:0] d_ref;
  logic [31:0] d_bus;
  logic [31:0] d_msk;
  logic odd_addr;
  logic addr_eq;
  logic data_eq;
  logic attr_ok;
  logic hit;
  logic wr_ctrl;
  logic bus_source_enable;
  logic xy_bus_pick;

  assign bus_source_enable = cycle_sel_reg[`BCM_XYE_BIT];
  assign xy_bus_pick = cycle_sel_reg[`BCM_XYS_BIT];
  assign wr_ctrl = reg_req.wr && (reg_req.addr == `BCM_OFF_CTRL);

  // condition registers, cleared only by the power-on reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      brk_addr_reg <= `BCM_RST32;
      amask_reg <= `BCM_RST32;
      brk_data_reg <= `BCM_RST32;
      dmask_reg <= `BCM_RST32;
      cycle_sel_reg <= `BCM_RST10;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        `BCM_OFF_ADDR: brk_addr_reg <= reg_req.wdata;
        `BCM_OFF_AMASK: amask_reg <= reg_req.wdata;
        `BCM_OFF_DATA: brk_data_reg <= reg_req.wdata;
        `BCM_OFF_DMASK: dmask_reg <= reg_req.wdata;
        `BCM_OFF_CYCLE: cycle_sel_reg <= reg_req.wdata[`BCM_CYCLE_RNG];
        default: ;
      endcase
    end
  end

  // data-break enable lives in the control word
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dbe_reg <= 1'b0;
    end else if (wr_ctrl) begin
      dbe_reg <= reg_req.wdata[`BCM_DBE_BIT];
    end
  end

  // pick reference, bus and mask words; unused positions are forced masked
  always_comb begin
    a_ref = brk_addr_reg;
    a_bus = bus_cycle.laddr;
    a_msk = amask_reg;
    d_ref = brk_data_reg;
    d_bus = bus_cycle.ldata;
    d_msk = dmask_reg;
    odd_addr = bus_cycle.laddr[0];
    if (bus_source_enable && !xy_bus_pick) begin
      // x bus: upper halves, address bit 0 not compared
      a_ref = {`BCM_HI_NONE, brk_addr_reg[31:17], 1'b0};
      a_bus = {`BCM_HI_NONE, bus_cycle.xaddr[15:1], 1'b0};
      a_msk = {`BCM_HI_ALL, amask_reg[31:17], 1'b1};
      d_ref = {`BCM_HI_NONE, brk_data_reg[31:16]};
      d_bus = {`BCM_HI_NONE, bus_cycle.xdata};
      d_msk = {`BCM_HI_ALL, dmask_reg[31:16]};
      odd_addr = bus_cycle.xaddr[0];
    end else if (bus_source_enable) begin
      // y bus: lower halves
      a_ref = {`BCM_HI_NONE, brk_addr_reg[15:1], 1'b0};
      a_bus = {`BCM_HI_NONE, bus_cycle.yaddr[15:1], 1'b0};
      a_msk = {`BCM_HI_ALL, amask_reg[15:1], 1'b1};
      d_ref = {`BCM_HI_NONE, brk_data_reg[15:0]};
      d_bus = {`BCM_HI_NONE, bus_cycle.ydata};
      d_msk = {`BCM_HI_ALL, dmask_reg[15:0]};
      odd_addr = bus_cycle.yaddr[0];
    end
    // byte breaks look at one lane only, all other data bits drop out
    if (cycle_sel_reg[`BCM_SIZE_RNG] == `BCM_SZ_BYTE) begin
      d_msk = d_msk | ~(odd_addr ? `BCM_LANE_EVEN : `BCM_LANE_ODD);
      d_msk[31:16] = `BCM_HI_ALL;
    end
  end

  bcm_masked_cmp u_addr_cmp (
    .ref_val(a_ref),
    .bus_val(a_bus),
    .mask(a_msk),
    .eq(addr_eq)
  );

  bcm_masked_cmp u_data_cmp (
    .ref_val(d_ref),
    .bus_val(d_bus),
    .mask(d_msk),
    .eq(data_eq)
  );

  bcm_attr_match u_attr (
    .sel(cycle_sel_reg[7:0]),
    .cyc(bus_cycle),
    .ok(attr_ok)
  );

  // every enabled comparison must agree in the same cycle
  assign hit = bus_cycle.valid && addr_eq && attr_ok &&
               (!dbe_reg || data_eq);

  // registered match: one pulse per matching cycle, at the next edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= hit;
    end
  end

  // sticky flags; a match in the clearing cycle wins so no event is lost
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      core_flag_reg <= 1'b0;
      dma_flag_reg <= 1'b0;
    end else begin
      if (hit && !bus_cycle.dma) begin
        core_flag_reg <= 1'b1;
      end else if (wr_ctrl && !reg_req.wdata[`BCM_CORE_FLAG_BIT]) begin
        core_flag_reg <= 1'b0;
      end
      if (hit && bus_cycle.dma) begin
        dma_flag_reg <= 1'b1;
      end else if (wr_ctrl && !reg_req.wdata[`BCM_DMA_FLAG_BIT]) begin
        dma_flag_reg <= 1'b0;
      end
    end
  end

  // read data stand one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= `BCM_RST32;
    end else begin
      rdata_reg <= `BCM_RST32;
      if (reg_req.rd) begin
        case (reg_req.addr)
          `BCM_OFF_ADDR: rdata_reg <= brk_addr_reg;
          `BCM_OFF_AMASK: rdata_reg <= amask_reg;
          `BCM_OFF_DATA: rdata_reg <= brk_data_reg;
          `BCM_OFF_DMASK: rdata_reg <= dmask_reg;
          `BCM_OFF_CYCLE: rdata_reg[`BCM_CYCLE_RNG] <= cycle_sel_reg;
          `BCM_OFF_CTRL: begin
            rdata_reg[`BCM_DBE_BIT] <= dbe_reg;
            rdata_reg[`BCM_CORE_FLAG_BIT] <= core_flag_reg;
            rdata_reg[`BCM_DMA_FLAG_BIT] <= dma_flag_reg;
          end
          default: ;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign chb_match = match_reg;
  assign core_match_flag = core_flag_reg;
  assign dma_match_flag = dma_flag_reg;
  assign data_break_enable = dbe_reg;

  // checks of the comparator against its configuration
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_lbus_addr;
    bus_cycle.valid && !bus_source_enable && cycle_sel_reg[7:0] == 8'h00 && !dbe_reg &&
    amask_reg == 32'h0000_0000 && bus_cycle.laddr == brk_addr_reg |=> chb_match;
  endproperty
  a_lbus_addr: assert property (p_lbus_addr) else $error("full address hit missed");

  property p_addr_miss;
    !bus_source_enable && amask_reg == 32'h0000_0000 && bus_cycle.laddr != brk_addr_reg
    |=> !chb_match;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("unmasked address miss matched");

  property p_xbus_pick;
    bus_cycle.valid && bus_source_enable && !xy_bus_pick && cycle_sel_reg[7:0] == 8'h00 && !dbe_reg &&
    amask_reg == 32'h0000_0000 && bus_cycle.xaddr[15:1] == brk_addr_reg[31:17]
    |=> chb_match;
  endproperty
  a_xbus_pick: assert property (p_xbus_pick) else $error("x bus hit missed");

  property p_owner;
    cycle_sel_reg[7:6] == 2'h1 && bus_cycle.dma |=> !chb_match;
  endproperty
  a_owner: assert property (p_owner) else $error("dma cycle matched core owner");

  property p_type;
    cycle_sel_reg[5:4] == 2'h1 && !bus_cycle.fetch |=> !chb_match;
  endproperty
  a_type: assert property (p_type) else $error("data access matched fetch select");

  property p_dir;
    cycle_sel_reg[3:2] == 2'h2 && !bus_cycle.write |=> !chb_match;
  endproperty
  a_dir: assert property (p_dir) else $error("read matched write select");

  property p_size;
    cycle_sel_reg[1:0] == 2'h3 && bus_cycle.size != 2'h3 |=> !chb_match;
  endproperty
  a_size: assert property (p_size) else $error("short access matched longword");

  property p_data;
    dbe_reg && !bus_source_enable && dmask_reg == 32'h0000_0000 && cycle_sel_reg[1:0] == 2'h3 &&
    bus_cycle.ldata != brk_data_reg |=> !chb_match;
  endproperty
  a_data: assert property (p_data) else $error("data mismatch matched");

  // sticky flag and data-enable checks; a clear written in the match cycle is legal, so it is excluded
  property p_flag;
    bus_cycle.valid && !bus_cycle.dma ##1 chb_match && !wr_ctrl
    |-> core_match_flag ##1 core_match_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("core flag not sticky");

  property p_dma_flag;
    hit && bus_cycle.dma |=> dma_match_flag;
  endproperty
  a_dma_flag: assert property (p_dma_flag) else $error("dma flag not set");

  property p_flag_hold;
    core_match_flag && !wr_ctrl |=> core_match_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("core flag dropped");

  property p_flag_clear;
    wr_ctrl && !reg_req.wdata[`BCM_CORE_FLAG_BIT] && !(hit && !bus_cycle.dma)
    |=> !core_match_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_dbe;
    wr_ctrl |=> data_break_enable == $past(reg_req.wdata[`BCM_DBE_BIT]);
  endproperty
  a_dbe: assert property (p_dbe) else $error("data enable not stored");

  // bus selection and data lane checks
  property p_ybus_pick;
    bus_cycle.valid && bus_source_enable && xy_bus_pick && cycle_sel_reg[7:0] == 8'h00 && !dbe_reg &&
    amask_reg[15:1] == 15'h0000 && bus_cycle.yaddr[15:1] == brk_addr_reg[15:1]
    |=> chb_match;
  endproperty
  a_ybus_pick: assert property (p_ybus_pick) else $error("y bus hit missed");

  property p_byte_lane;
    dbe_reg && !bus_source_enable && cycle_sel_reg[`BCM_SIZE_RNG] == `BCM_SZ_BYTE && !bus_cycle.laddr[0] &&
    dmask_reg[15:8] == 8'h00 && bus_cycle.ldata[15:8] != brk_data_reg[15:8]
    |=> !chb_match;
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("even lane miss matched");

  property p_xdata;
    bus_source_enable && !xy_bus_pick && dbe_reg && cycle_sel_reg[`BCM_SIZE_RNG] == `BCM_SZ_LONG &&
    dmask_reg[31:16] == 16'h0000 && bus_cycle.xdata != brk_data_reg[31:16]
    |=> !chb_match;
  endproperty
  a_xdata: assert property (p_xdata) else $error("x data miss matched");

  // an idle bus can never raise the match pulse
  property p_valid;
    !bus_cycle.valid |=> !chb_match;
  endproperty
  a_valid: assert property (p_valid) else $error("idle bus matched");

  property p_reserved;
    reg_req.rd && reg_req.addr == `BCM_OFF_CYCLE |=> reg_rdata[31:10] == 22'h00_0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  c_lbus_hit: cover property (!bus_source_enable && chb_match);
  c_xy_hit: cover property (bus_source_enable && bus_cycle.valid ##1 chb_match);
  c_dma_flag: cover property (!dma_match_flag ##1 dma_match_flag);
  c_byte_hit: cover property (cycle_sel_reg[`BCM_SIZE_RNG] == `BCM_SZ_BYTE && dbe_reg && hit);
  c_flag_clear: cover property (core_match_flag ##1 !core_match_flag);
endmodule // bcm_matcher_top

// ==== sim/bcm_bus_model.sv ====
// far-side bus model: core and dma bus cycles seen by the matcher
`timescale 1ns/1ps
module bcm_bus_model
  import bcm_pkg::*;
(
  input wire logic sys_clk,
  output bcm_cycle_t bus_cycle
);
  initial bus_cycle = '0;

  // one bus cycle per call; the idle bus shows flipped values, never a stale copy
  task automatic send(input bcm_cycle_t c);
    @(posedge sys_clk);
    bus_cycle <= c;
    @(posedge sys_clk);
    bus_cycle <= {1'b0, ~c[$bits(c)-2:0]}; // valid low means nothing may match
  endtask
endmodule // bcm_bus_model

// ==== sim/bcm_matcher_top_test.sv ====
// self-checking testbench of the channel b break matcher
`timescale 1ns/1ps
module bcm_matcher_top_test
  import bcm_pkg::*;
;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  bcm_reg_req_t reg_req = '0;
  logic [31:0] reg_rdata;
  bcm_cycle_t bus_cycle;
  bcm_cycle_t c;
  logic chb_match, core_match_flag, dma_match_flag, data_break_enable;
  int errors = 0;
  int compares = 0;

  always #4 sys_clk = ~sys_clk;

  bcm_matcher_top i_bcm_matcher_top (.sys_clk(sys_clk), .nrst(nrst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .bus_cycle(bus_cycle), .chb_match(chb_match),
    .core_match_flag(core_match_flag), .dma_match_flag(dma_match_flag),
    .data_break_enable(data_break_enable));
  bcm_bus_model i_bcm_bus_model (.sys_clk(sys_clk), .bus_cycle(bus_cycle));

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // strobes last one cycle, released at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    reg_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge sys_clk);
    reg_req <= '0;
    #1 chk("read data", reg_rdata, exp);
  endtask

  // one bus cycle, match result looked at in the cycle after it
  task automatic try(input string nm, input logic exp);
    i_bcm_bus_model.send(c);
    #1 chk(nm, {31'h0, chb_match}, {31'h0, exp});
  endtask

  task automatic attr(input logic [7:0] sel, input logic [4:0] f, input logic exp);
    wr(8'h10, {24'h0, sel});
    {c.dma, c.fetch, c.write, c.size} = f;
    try("attribute match", exp);
  endtask

  task automatic t_regs;
    // an unmapped write must leave every register untouched
    wr(8'h20, 32'hffff_ffff);
    for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    // reserved bits are written as zero, as software must
    wr(8'h10, 32'h0000_03ff);
    rd(8'h10, 32'h0000_03ff);
    wr(8'h00, 32'ha5a5_5a5a);
    rd(8'h00, 32'ha5a5_5a5a);
  endtask

  // power-on reset in mid-run: conditions, enable and flags back to zero
  task automatic t_reset;
    wr(8'h0c, 32'h0000_00ff);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    #1 chk("core flag after reset", {31'h0, core_match_flag}, 32'h0000_0000);
    chk("data enable after reset", {31'h0, data_break_enable}, 32'h0000_0000);
    for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0000_0000);
  endtask

  task automatic t_addr;
    wr(8'h10, 32'h0000_0000);
    wr(8'h00, 32'h1234_5678);
    c = '0;
    c.valid = 1'b1;
    c.size = 2'h3;
    c.laddr = 32'h1234_5678;
    try("full address", 1'b1);
    chk("core flag", {31'h0, core_match_flag}, 32'h0000_0001);
    chk("dma flag", {31'h0, dma_match_flag}, 32'h0000_0000);
    c.laddr = 32'h1234_5679;
    try("address off by one bit", 1'b0);
    wr(8'h04, 32'h0000_0001);
    try("masked address bit", 1'b1);
    c.valid = 1'b0;
    try("no bus cycle", 1'b0);
    c.valid = 1'b1;
    // x and y halves of the break address
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'habcd_1234);
    wr(8'h10, 32'h0000_0200);
    c.laddr = 32'h0000_0000;
    c.xaddr = 16'habcc;
    try("x address", 1'b1);
    c.xaddr = 16'habce;
    try("x address bit 1 off", 1'b0);
    wr(8'h04, 32'h0002_0000);
    try("x address masked", 1'b1);
    wr(8'h10, 32'h0000_0300);
    c.yaddr = 16'h1235;
    try("y address", 1'b1);
    c.yaddr = 16'h1236;
    try("y address bit 1 off", 1'b0);
  endtask

  task automatic t_attr;
    wr(8'h04, 32'hffff_ffff);
    attr(8'h40, 5'b10011, 1'b0);
    attr(8'h80, 5'b10011, 1'b1);
    chk("dma flag", {31'h0, dma_match_flag}, 32'h0000_0001);
    attr(8'hc0, 5'b00011, 1'b1);
    attr(8'h80, 5'b00011, 1'b0);
    attr(8'h10, 5'b00011, 1'b0);
    attr(8'h10, 5'b01011, 1'b1);
    attr(8'h20, 5'b00011, 1'b1);
    attr(8'h30, 5'b01011, 1'b1);
    attr(8'h04, 5'b00111, 1'b0);
    attr(8'h08, 5'b00111, 1'b1);
    attr(8'h0c, 5'b00011, 1'b1);
    attr(8'h01, 5'b00010, 1'b0);
    attr(8'h02, 5'b00010, 1'b1);
    attr(8'h03, 5'b00001, 1'b0);
    wr(8'h14, 32'h0000_0000);
    // flags settle after the write edge, so look just after it
    #1 chk("flags cleared", {30'h0, core_match_flag, dma_match_flag}, 32'h0000_0000);
  endtask

  task automatic t_data;
    wr(8'h10, 32'h0000_0001);
    wr(8'h08, 32'h0000_5500);
    wr(8'h14, 32'h0000_0080);
    #1 chk("data enable", {31'h0, data_break_enable}, 32'h0000_0001);
    c = '0;
    c.valid = 1'b1;
    c.size = 2'h1;
    c.ldata = 32'h1234_55ab;
    try("byte even lane", 1'b1);
    c.ldata = 32'h1234_56ab;
    try("byte even lane off", 1'b0);
    c.laddr = 32'h0000_0001;
    c.ldata = 32'hffff_ff00;
    try("byte odd lane", 1'b1);
    c.ldata = 32'hffff_ff01;
    try("byte odd lane off", 1'b0);
    wr(8'h10, 32'h0000_0003);
    c.size = 2'h3;
    c.ldata = 32'h0000_5501;
    try("long data off", 1'b0);
    wr(8'h0c, 32'h0000_0001);
    try("long data masked", 1'b1);
    wr(8'h0c, 32'h0000_0000);
    wr(8'h14, 32'h0000_0000);
    try("data not enabled", 1'b1);
    // x data half
    wr(8'h10, 32'h0000_0203);
    wr(8'h08, 32'h4321_0000);
    wr(8'h14, 32'h0000_0080);
    c.xdata = 16'h4321;
    try("x data", 1'b1);
    c.xdata = 16'h4320;
    try("x data off", 1'b0);
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    for (int i = 0; i < 50000; i++) @(posedge sys_clk);
    errors++;
    stop_test;
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs;
    t_addr;
    t_attr;
    t_data;
    t_reset;
    stop_test;
  end
endmodule // bcm_matcher_top_test
